// *** pkg/wdt_consts.vh ***
// Constants for the watchdog, sleep and reset status block.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ****************************************************************
// Timing of the watchdog oscillator
// ****************************************************************
`define WDT_PERIOD_MS 16'd18
`define HOLD_PERIOD_MS 16'd18
`define WDT_OSC_KHZ 16'd32
`define WDT_TIMEOUT_TICKS (`WDT_PERIOD_MS * `WDT_OSC_KHZ)
`define HOLD_TICKS (`HOLD_PERIOD_MS * `WDT_OSC_KHZ)
`define CNT_W 16
`define PRE_W 8
`define PRE_ZERO 8'h00
`define PRE_ONE 8'h01
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001

// ****************************************************************
// Option register layout
// ****************************************************************
`define OPT_W 8
`define OPTION_RESET 8'h3F
`define OPT_IMPL_MASK 8'h3F
`define OPT_ASSIGN_BIT 3
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0

// ****************************************************************
// Status and event register layout
// ****************************************************************
`define STAT_SLEEP_BIT 0
`define STAT_HOLD_BIT 1
`define STAT_POWERDOWN_BIT 3
`define STAT_TIMEOUT_BIT 4
`define EVT_W 3
`define EVT_TIMEOUT_BIT 0
`define EVT_WAKE_BIT 1
`define EVT_PIN_BIT 2
`define EVT_ZERO 3'h0

// ****************************************************************
// Register byte addresses and bus
// ****************************************************************
`define ADDR_W 4
`define ADDR_OPTION 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_EVENT 4'h8
`define ADDR_MASK 4'hC
`define DATA_W 32
`define DATA_ZERO 32'h00000000
`define BYTE_ZERO 8'h00
`define PORT_W 8
`define PORT_ZERO 8'h00

`endif

// *** rtl/level_sync.v ***
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ns
module level_sync (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_async,
  output reg o_sync
);

  reg stage1;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// *** rtl/tick_counter.v ***
// Tick counter that reports expiry when its limit is reached.
`timescale 1ns/1ns
`include "wdt_consts.vh"
module tick_counter #(
  parameter [`CNT_W-1:0] LIMIT = `WDT_TIMEOUT_TICKS
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_clear,
  input wire i_step,
  output wire o_expire
);

  reg [`CNT_W-1:0] count;

  // A clear in the same cycle suppresses expiry, so a restart always wins.
  assign o_expire = i_step && !i_clear && (count == LIMIT - `CNT_ONE);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      count <= `CNT_ZERO;
    end else if (i_clear || o_expire) begin
      count <= `CNT_ZERO;
    end else if (i_step) begin
      count <= count + `CNT_ONE;
    end
  end

endmodule

// *** rtl/watchdog_sleep_reset_status.v ***
// Watchdog, power-down control and reset cause flags with an Avalon-MM slave.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "wdt_consts.vh"
// Behaviour
// - Watchdog counts ticks of its own oscillator, also while core clock stops.
// - Watchdog time-out causes full device reset, awake or asleep.
// - Watchdog reset clears the time-out flag, status bit 4.
// - Configuration enable at zero disables the watchdog for as long as it stays zero.
// - Without prescaler the watchdog times out after nominal 18 ms.
// - Option register can assign shared prescaler, up to 1:128.
// - Clear instruction restarts watchdog counter and assigned prescaler.
// - Sleep instruction restarts watchdog counter and assigned prescaler.
// - Flags after reset: POR 11, pin wake 10, watchdog 01, watchdog wake 00.
// - Master-clear pulse in normal running leaves both flags untouched.
// - Only power-up, time-out, sleep and clear instruction change flags.
// - Time-out and sleep act regardless of current flag values.
// - Sleep restarts watchdog, sets time-out, clears power-down, stops oscillator.
// - Port pins keep their pre-sleep drive state during power-down.
// - Watchdog reset is internal and never drives master-clear pin.
// - Only master-clear or enabled time-out wake; both reset the device.
// - Watchdog counter is cleared on wake, whatever the source.
// - Time-out also starts the device hold timer holding core in reset.
module watchdog_sleep_reset_status #(
  parameter [`CNT_W-1:0] TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS,
  parameter [`CNT_W-1:0] HOLD_TICKS = `HOLD_TICKS
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_master_clear_pin_n,
  input wire i_wdt_osc,
  input wire i_watchdog_config_enable,
  input wire i_watchdog_clear_instr,
  input wire i_sleep_instr,
  input wire [`PORT_W-1:0] i_port_out,
  input wire [`PORT_W-1:0] i_port_oe,
  input wire [`ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [`DATA_W-1:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [`DATA_W-1:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output wire o_core_reset,
  output wire o_osc_drv_en,
  output wire o_timeout_flag,
  output wire o_powerdown_flag,
  output reg [`PORT_W-1:0] o_port_out,
  output reg [`PORT_W-1:0] o_port_oe,
  output wire o_irq
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;

  reg timeout_flag;
  reg powerdown_flag;
  reg [`OPT_W-1:0] timer_prescale_option;
  reg [`PRE_W-1:0] pre_cnt;
  reg [`EVT_W-1:0] evt_status;
  reg [`EVT_W-1:0] evt_mask;
  reg osc_prev;
  reg pin_prev;
  reg bus_ack;

  wire pin_high;
  wire osc_level;
  wire osc_tick;
  wire wdt_expire;
  wire hold_expire;
  wire wdt_step;
  wire wdt_clear;
  wire in_hold;
  wire in_run;
  wire in_sleep;
  wire run_sleep;
  wire run_clear;
  wire enter_reset;
  wire wake;
  wire prescaler_assign;
  wire [2:0] prescale_rate;
  wire bus_req;
  wire bus_done;
  wire wr_lane0;
  wire [`EVT_W-1:0] evt_set;
  wire [`EVT_W-1:0] evt_w1c;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // True when the low rate bits of the prescaler are all ones.
  function prescale_hit;
    input [`PRE_W-1:0] cnt;
    input [2:0] rate;
    reg [`PRE_W-1:0] mask;
    begin
      mask = (`PRE_ONE << rate) - `PRE_ONE;
      prescale_hit = ((cnt & mask) == mask);
    end
  endfunction

  // Byte of data that a read at the given address returns.
  function [`OPT_W-1:0] read_byte;
    input [`ADDR_W-1:0] addr;
    input [`OPT_W-1:0] status_byte;
    input [`EVT_W-1:0] evt;
    input [`EVT_W-1:0] msk;
    begin
      case (addr)
        `ADDR_STATUS: read_byte = status_byte;
        `ADDR_EVENT: read_byte = {5'h00, evt};
        `ADDR_MASK: read_byte = {5'h00, msk};
        default: read_byte = `BYTE_ZERO;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  level_sync u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_master_clear_pin_n),
    .o_sync(pin_high)
  );

  // The watchdog oscillator is free-running and not stopped by sleep.
  level_sync u_osc_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_wdt_osc),
    .o_sync(osc_level)
  );

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      osc_prev <= osc_level;
      pin_prev <= pin_high;
    end
  end

  assign osc_tick = osc_level && !osc_prev;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  assign in_hold = state[0];
  assign in_run = state[1];
  assign in_sleep = state[2];
  assign run_sleep = in_run && i_sleep_instr;
  assign run_clear = in_run && i_watchdog_clear_instr && !i_sleep_instr;
  assign wake = in_sleep && (!pin_high || wdt_expire);
  assign enter_reset = (in_run || in_sleep) && (!pin_high || wdt_expire);

  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (pin_high && hold_expire) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pin_high || wdt_expire) begin
          next_state = ST_HOLD;
        end else if (i_sleep_instr) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Wake is always a reset, never a resumption.
        if (!pin_high || wdt_expire) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // The core is held until the pin is high and the hold timer has run out.
  assign o_core_reset = in_hold;
  assign o_osc_drv_en = !in_sleep;

  // ****************************************************************
  // Hold timer
  // ****************************************************************
  // Restarted whenever the pin is low, so the hold counts from pin release.
  tick_counter #(
    .LIMIT(HOLD_TICKS)
  ) u_hold (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!in_hold || !pin_high),
    .i_step(osc_tick),
    .o_expire(hold_expire)
  );

  // ****************************************************************
  // Watchdog counter and prescaler
  // ****************************************************************
  assign prescaler_assign = timer_prescale_option[`OPT_ASSIGN_BIT];
  assign prescale_rate = timer_prescale_option[`OPT_RATE_HI:`OPT_RATE_LO];

  // Prescaler output gates watchdog steps only when it is assigned here.
  assign wdt_step = osc_tick &&
    (!prescaler_assign || prescale_hit(pre_cnt, prescale_rate));

  // Pin-low during sleep also restarts the counter; a time-out wake
  // restarts it through the counter's own expiry.
  assign wdt_clear = !i_watchdog_config_enable
    || in_hold
    || run_clear
    || run_sleep
    || (in_sleep && !pin_high);

  tick_counter #(
    .LIMIT(TIMEOUT_TICKS)
  ) u_watchdog_counter (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(wdt_clear),
    .i_step(wdt_step),
    .o_expire(wdt_expire)
  );

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_cnt <= `PRE_ZERO;
    end else if (!prescaler_assign || wdt_clear || wdt_expire) begin
      pre_cnt <= `PRE_ZERO;
    end else if (osc_tick) begin
      pre_cnt <= pre_cnt + `PRE_ONE;
    end
  end

  // ****************************************************************
  // Reset cause flags
  // ****************************************************************
  // The pin never appears here, so a pin reset leaves both flags alone.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (wdt_expire) begin
      timeout_flag <= 1'b0;
    end else if (run_sleep) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (run_clear) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end
  end

  assign o_timeout_flag = timeout_flag;
  assign o_powerdown_flag = powerdown_flag;

  // ****************************************************************
  // Port pin hold
  // ****************************************************************
  // Registered so the state seen at the sleep instruction is what freezes.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_port_out <= `PORT_ZERO;
      o_port_oe <= `PORT_ZERO;
    end else if (!in_sleep) begin
      o_port_out <= i_port_out;
      o_port_oe <= i_port_oe;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  // One wait state on every access keeps read data registered.
  assign bus_req = i_avs_read || i_avs_write;
  assign bus_done = bus_req && bus_ack;
  assign wr_lane0 = bus_done && i_avs_write && i_avs_byteenable[0];
  assign o_avs_waitrequest = !bus_ack;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus_ack <= 1'b0;
      o_avs_readdata <= `DATA_ZERO;
    end else begin
      bus_ack <= bus_req && !bus_ack;
      if (bus_req && !bus_ack) begin
        o_avs_readdata <= {24'h000000, read_byte(i_avs_address,
          {3'h0, timeout_flag, powerdown_flag, 1'b0, in_hold, in_sleep},
          evt_status, evt_mask)};
      end
    end
  end

  // Device reset restores the option register and beats a bus write.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      timer_prescale_option <= `OPTION_RESET;
    end else if (enter_reset) begin
      timer_prescale_option <= `OPTION_RESET;
    end else if (wr_lane0 && (i_avs_address == `ADDR_OPTION)) begin
      timer_prescale_option <= i_avs_writedata[`OPT_W-1:0] & `OPT_IMPL_MASK;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign evt_set = {pin_prev && !pin_high, wake, wdt_expire};
  assign evt_w1c = (wr_lane0 && (i_avs_address == `ADDR_EVENT)) ?
    i_avs_writedata[`EVT_W-1:0] : `EVT_ZERO;

  // A new event in the clearing cycle stays set.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      evt_status <= `EVT_ZERO;
      evt_mask <= `EVT_ZERO;
    end else begin
      evt_status <= (evt_status & ~evt_w1c) | evt_set;
      if (wr_lane0 && (i_avs_address == `ADDR_MASK)) begin
        evt_mask <= i_avs_writedata[`EVT_W-1:0];
      end
    end
  end

  assign o_irq = |(evt_status & evt_mask);

  // The master-clear pin is an input only; no reset path drives it.

endmodule

// *** verif/wdt_properties.sv ***
// Concurrent checks on the ports of the watchdog, sleep and reset status block.
`timescale 1ns/1ns
`include "wdt_consts.vh"
module wdt_properties #(
  parameter [`CNT_W-1:0] TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS,
  parameter [`CNT_W-1:0] HOLD_TICKS = `HOLD_TICKS
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_watchdog_config_enable,
  input wire i_watchdog_clear_instr,
  input wire i_sleep_instr,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_core_reset,
  input wire o_osc_drv_en,
  input wire o_timeout_flag,
  input wire o_powerdown_flag,
  input wire [`PORT_W-1:0] o_port_out,
  input wire [`PORT_W-1:0] o_port_oe
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_expiry_hold;
    $fell(o_timeout_flag) |-> ##[0:1] o_core_reset;
  endproperty
  a_expiry_hold: assert property (p_expiry_hold)
    else $error("time-out flag fell without core reset");
  property p_sleep_entry;
    i_sleep_instr && !o_core_reset && o_osc_drv_en |=>
      !o_osc_drv_en && o_timeout_flag && !o_powerdown_flag;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry state wrong");
  property p_clear_sets;
    i_watchdog_clear_instr && !i_sleep_instr && !o_core_reset && o_osc_drv_en |=>
      o_timeout_flag && o_powerdown_flag;
  endproperty
  a_clear_sets: assert property (p_clear_sets)
    else $error("clear instruction did not set both flags");
  property p_disabled;
    !i_watchdog_config_enable && !$past(i_watchdog_config_enable) |-> !$fell(o_timeout_flag);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("time-out while watchdog disabled");
  property p_hold_flags;
    o_core_reset && $past(o_core_reset) |-> $stable(o_timeout_flag) && $stable(o_powerdown_flag);
  endproperty
  a_hold_flags: assert property (p_hold_flags)
    else $error("flags changed while core held");
  property p_wake_reset;
    $rose(o_osc_drv_en) |-> o_core_reset;
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("wake without device reset");
  property p_freeze;
    !o_osc_drv_en && !$past(o_osc_drv_en) |-> $stable(o_port_out) && $stable(o_port_oe);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("port drive moved during sleep");
  property p_wait_answer;
    $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("bus answer not after one wait cycle");
  property p_wait_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");
endmodule
bind watchdog_sleep_reset_status wdt_properties #(.TIMEOUT_TICKS(TIMEOUT_TICKS),
  .HOLD_TICKS(HOLD_TICKS)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_watchdog_config_enable(i_watchdog_config_enable),
  .i_watchdog_clear_instr(i_watchdog_clear_instr), .i_sleep_instr(i_sleep_instr),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_core_reset(o_core_reset), .o_osc_drv_en(o_osc_drv_en), .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag), .o_port_out(o_port_out), .o_port_oe(o_port_oe));

// *** verif/core_model.sv ***
// Behavioural processor core that issues clear and sleep instructions.
`timescale 1ns/1ns
`include "wdt_consts.vh"
module core_model (
  input wire i_clk,
  output reg o_clear,
  output reg o_sleep,
  output reg [`PORT_W-1:0] o_port_out,
  output reg [`PORT_W-1:0] o_port_oe
);
  // The core starts idle, with no instruction pending and its ports quiet.
  initial begin
    o_clear = 1'b0;
    o_sleep = 1'b0;
    o_port_out = `PORT_ZERO;
    o_port_oe = `PORT_ZERO;
  end
  // ****************************************************************
  // Port drive and instruction pulses
  // ****************************************************************
  // Port values move every cycle, so only the device can hold them still in sleep.
  always @(posedge i_clk) begin
    o_port_out <= o_port_out + 8'h01;
    o_port_oe <= ~o_port_out;
  end
  // One-cycle pulse; the core model keeps running while asleep and does not wait for a device reset.
  task issue(input is_sleep);
    begin
      @(posedge i_clk);
      o_clear <= !is_sleep;
      o_sleep <= is_sleep;
      @(posedge i_clk);
      o_clear <= 1'b0;
      o_sleep <= 1'b0;
    end
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking testbench for the watchdog, sleep and reset status block.
`timescale 1ns/1ns
`include "wdt_consts.vh"
module tb;
  // ****************************************************************
  // Stimulus, checks and scenarios
  // ****************************************************************
  localparam integer TO_T = 4;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg pin_n = 1'b1;
  reg osc = 1'b0;
  reg cfg_en = 1'b1;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [3:0] be = 4'hF;
  reg [`ADDR_W-1:0] addr = `ADDR_OPTION;
  reg [`DATA_W-1:0] wdata = `DATA_ZERO;
  reg [`DATA_W-1:0] q;
  reg [31:0] cyc = 32'h0;
  wire [`DATA_W-1:0] rdata;
  wire wreq, core_rst, osc_en, to_f, pd_f, irq, clr, slp;
  wire [`PORT_W-1:0] pout, poe, q_out, q_oe;
  integer fails = 0;
  integer checks = 0;
  core_model u_core (.i_clk(i_clk), .o_clear(clr), .o_sleep(slp), .o_port_out(pout),
    .o_port_oe(poe));
  watchdog_sleep_reset_status #(.TIMEOUT_TICKS(16'h0004), .HOLD_TICKS(16'h0004)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_clear_pin_n(pin_n), .i_wdt_osc(osc),
    .i_watchdog_config_enable(cfg_en), .i_watchdog_clear_instr(clr), .i_sleep_instr(slp),
    .i_port_out(pout), .i_port_oe(poe), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_core_reset(core_rst),
    .o_osc_drv_en(osc_en), .o_timeout_flag(to_f), .o_powerdown_flag(pd_f),
    .o_port_out(q_out), .o_port_oe(q_oe), .o_irq(irq));
  initial forever #4 i_clk = ~i_clk;
  // The oscillator is slower than the core clock by eight, as the synchroniser needs.
  always @(posedge i_clk) begin
    cyc <= cyc + 32'h1;
    osc <= cyc[2];
    if (cyc == 32'd40000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task cmp1(input got, input exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
      end
    end
  endtask
  task cmpw(input [`DATA_W-1:0] got, input [`DATA_W-1:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input is_wr, input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d);
    integer n;
    begin
      n = 0;
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= is_wr;
      rd <= !is_wr;
      @(posedge i_clk);
      while (wreq !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge i_clk);
      end
      q = rdata;
      cmp1(wreq, 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task wait_core(input target, input integer maxc, output integer n);
    begin
      n = 0;
      while (core_rst !== target && n < maxc) begin
        n = n + 1;
        @(posedge i_clk);
      end
      cmp1(core_rst, target);
    end
  endtask
  task t_por;
    integer n;
    begin
      @(posedge i_clk);
      cmp1(core_rst, 1'b1);
      cmp1(to_f & pd_f, 1'b1);
      wait_core(1'b0, 200, n);
      bus(1'b0, `ADDR_STATUS, `DATA_ZERO);
      cmpw(q, 32'h00000018);
    end
  endtask
  // A slow count shortens to a late reset and a fast one to an early one.
  task t_period(input do_wr, input [7:0] opt, input integer ticks);
    integer n;
    begin
      if (do_wr) bus(1'b1, `ADDR_OPTION, {24'h000000, opt});
      u_core.issue(1'b0);
      wait_core(1'b1, ticks * 8 + 32, n);
      cmp1(n >= (ticks - 1) * 8, 1'b1);
      cmp1(to_f, 1'b0);
      cmp1(pd_f, 1'b1);
      repeat (16) @(posedge i_clk);
      cmp1(core_rst, 1'b1);
      wait_core(1'b0, 200, n);
    end
  endtask
  task t_clear;
    begin
      bus(1'b1, `ADDR_OPTION, `DATA_ZERO);
      repeat (12) begin
        repeat (14) @(posedge i_clk);
        u_core.issue(1'b0);
      end
      cmp1(core_rst, 1'b0);
      cmp1(to_f & pd_f, 1'b1);
    end
  endtask
  task t_disabled;
    begin
      cfg_en <= 1'b0;
      repeat (400) @(posedge i_clk);
      cmp1(core_rst, 1'b0);
      cmp1(to_f, 1'b1);
      cfg_en <= 1'b1;
    end
  endtask
  task t_sleep_wdt;
    reg [`PORT_W-1:0] held;
    integer n;
    begin
      u_core.issue(1'b1);
      @(posedge i_clk);
      held = q_out;
      cmp1(osc_en, 1'b0);
      cmp1(to_f & !pd_f, 1'b1);
      repeat (16) @(posedge i_clk);
      cmpw({24'h000000, q_out}, {24'h000000, held});
      u_core.issue(1'b0);
      wait_core(1'b1, TO_T * 8 + 40, n);
      cmp1(to_f | pd_f, 1'b0);
      bus(1'b0, `ADDR_EVENT, `DATA_ZERO);
      cmpw(q, 32'h00000003);
      bus(1'b1, `ADDR_MASK, 32'h00000002);
      repeat (2) @(posedge i_clk);
      cmp1(irq, 1'b1);
      bus(1'b0, `ADDR_MASK, `DATA_ZERO);
      cmpw(q, 32'h00000002);
      // A write without lane 0 enabled must leave the mask alone.
      be <= 4'h0;
      bus(1'b1, `ADDR_MASK, 32'h00000007);
      be <= 4'hF;
      bus(1'b0, `ADDR_MASK, `DATA_ZERO);
      cmpw(q, 32'h00000002);
      bus(1'b1, `ADDR_EVENT, 32'h00000003);
      repeat (2) @(posedge i_clk);
      cmp1(irq, 1'b0);
      bus(1'b0, 4'h2, `DATA_ZERO);
      cmpw(q, `DATA_ZERO);
      bus(1'b0, `ADDR_OPTION, `DATA_ZERO);
      cmpw(q, `DATA_ZERO);
      wait_core(1'b0, 200, n);
    end
  endtask
  task t_pin(input asleep);
    integer n;
    begin
      if (asleep) u_core.issue(1'b1);
      repeat (8) @(posedge i_clk);
      pin_n <= 1'b0;
      wait_core(1'b1, 20, n);
      cmp1(to_f & !pd_f, 1'b1);
      pin_n <= 1'b1;
      wait_core(1'b0, 200, n);
      cmp1(to_f & !pd_f, 1'b1);
    end
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_por;
    t_period(1'b0, 8'h3F, TO_T << 7);
    t_period(1'b1, 8'h07, TO_T);
    t_period(1'b1, 8'h0B, TO_T << 3);
    t_period(1'b1, 8'h08, TO_T);
    t_clear;
    t_disabled;
    t_sleep_wdt;
    t_pin(1'b1);
    t_pin(1'b0);
    wrap_up;
  end
endmodule
